// ---- hw/mio_mapper.sv ----
// Motion I/O function mapper with a classic Wishbone register slave
`timescale 1ns/100ps
module mio_mapper (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [mio_pkg::NUM_IN-1:0] in_pin,
  output logic [mio_pkg::NUM_OUT-1:0] out_pin,
  input wire mio_pkg::mio_motion_t motion,
  output mio_pkg::mio_action_t action,
  output logic jog_enable_flag,
  output logic stall_detect_mode
);
  import mio_pkg::*;

  mio_line_cfg_t in_cfg_q [NUM_IN];
  mio_line_cfg_t out_cfg_q [NUM_OUT];
  logic [31:0] ctrl_q;
  logic [NUM_OUT-1:0] gp_out_q;
  logic [3:0] event_q;
  logic [NUM_IN-1:0] act_q;
  logic [NUM_IN-1:0] act_d;
  logic [NUM_OUT-1:0] out_d;
  logic [NUM_OUT-1:0] cond;
  logic [31:0] rd_d;
  logic wr_go;
  logic rd_go;
  logic [3:0] wline;
  logic [4:0] wtype;
  logic wpol;
  logic in_ok;
  logic out_ok;
  logic in_wr;
  logic out_wr;
  logic [3:0] ev_set;
  mio_action_t action_d;

  // Request taken while ack is low; a write lands on the edge that sees ack high
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign jog_enable_flag = ctrl_q[CTRL_JOG_EN];
  assign stall_detect_mode = ctrl_q[CTRL_STALL_MODE];

  // Setup command fields
  // three fields
  assign wline = wb_dat_i[LINE_LSB +: 4];
  assign wtype = wb_dat_i[TYPE_LSB +: 5];
  assign wpol = wb_dat_i[POL_BIT];

  // Legal input combinations
  always_comb begin
    in_ok = (wline >= 4'h1) && (wline <= 4'h4);
    unique case (wtype)
      IN_GP, IN_HOME, IN_LIM_POS, IN_LIM_NEG, IN_LAUNCH, IN_SOFT_STOP, IN_PAUSE,
      IN_JOG_POS, IN_JOG_NEG, IN_RESET: begin
      end
      IN_CAPTURE: begin
        in_ok = in_ok && (wline == 4'h1) && !ctrl_q[CTRL_SMALL_FRAME];
      end
      default: begin
        in_ok = 1'b0;
      end
    endcase
  end

  // Legal output combinations
  always_comb begin
    out_ok = (wline >= 4'h1) && (wline <= 4'h3);
    unique case (wtype)
      OUT_GP, OUT_MOVING, OUT_ERROR, OUT_STALL, OUT_VEL_CHG, OUT_LOCKED, OUT_TO_POS,
      OUT_HYB_ON, OUT_MAKEUP, OUT_ATTN: begin
      end
      OUT_TRIP: begin
        out_ok = out_ok && (wline == 4'h3) && !wpol;
      end
      default: begin
        out_ok = 1'b0;
      end
    endcase
  end

  // Whole-word writes only, so a setup command is never half applied
  assign in_wr = wr_go && (wb_adr_i == ADR_IN_CFG) && (wb_sel_i == 4'hF);
  assign out_wr = wr_go && (wb_adr_i == ADR_OUT_CFG) && (wb_sel_i == 4'hF);

  // Per-line configuration storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          in_cfg_q[gi] <= '{fn: RST_IN_TYPE, pol: RST_POL};
        end else if (in_wr && in_ok && (wline == 4'(gi + 1))) begin
          in_cfg_q[gi] <= '{fn: wtype, pol: wpol};
        end
      end
      assign act_d[gi] = in_cfg_q[gi].pol ? in_pin[gi] : !in_pin[gi];
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          out_cfg_q[gi] <= '{fn: RST_OUT_TYPE, pol: RST_POL};
        end else if (out_wr && out_ok && (wline == 4'(gi + 1))) begin
          out_cfg_q[gi] <= '{fn: wtype, pol: wpol};
        end
      end
      // Condition per output function
      always_comb begin
        unique case (out_cfg_q[gi].fn)
          OUT_GP: cond[gi] = gp_out_q[gi];
          OUT_MOVING: cond[gi] = motion.moving;
          OUT_ERROR: cond[gi] = motion.error;
          OUT_STALL: cond[gi] = motion.stall && ctrl_q[CTRL_STALL_MODE];
          OUT_VEL_CHG: cond[gi] = motion.vel_changing;
          OUT_LOCKED: cond[gi] = motion.locked_rotor;
          OUT_TO_POS: cond[gi] = motion.to_position;
          OUT_HYB_ON: cond[gi] = motion.hybrid_on;
          OUT_MAKEUP: cond[gi] = motion.makeup;
          OUT_TRIP: cond[gi] = motion.trip;
          OUT_ATTN: cond[gi] = |(motion.status & ctrl_q[CTRL_MASK_LSB +: 8]);
          default: cond[gi] = 1'b0;
        endcase
      end
      assign out_d[gi] = out_cfg_q[gi].pol ? cond[gi] : !cond[gi];
    end
  endgenerate

  // Output pins registered
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_pin <= '0;
    end else begin
      out_pin <= out_d;
    end
  end

  // Previous activity for edge-triggered functions
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end

  // Map active inputs onto actions; levels for held functions, edges for one-shots
  always_comb begin
    action_d = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      unique case (in_cfg_q[i].fn)
        IN_HOME: action_d.home |= act_d[i];
        IN_LIM_POS: action_d.limit_pos |= act_d[i];
        IN_LIM_NEG: action_d.limit_neg |= act_d[i];
        IN_LAUNCH: action_d.launch |= act_d[i] && !act_q[i];
        IN_SOFT_STOP: action_d.soft_stop |= act_d[i];
        IN_PAUSE: action_d.pause |= act_d[i];
        IN_JOG_POS: action_d.jog_pos |= act_d[i] && ctrl_q[CTRL_JOG_EN];
        IN_JOG_NEG: action_d.jog_neg |= act_d[i] && ctrl_q[CTRL_JOG_EN];
        IN_RESET: action_d.brk |= act_d[i] && !act_q[i];
        IN_CAPTURE: action_d.capture |= act_d[i] && !act_q[i];
        default: begin
        end
      endcase
    end
  end

  // Actions registered so downstream sees clean levels and one-cycle pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      action <= '0;
    end else begin
      action <= action_d;
    end
  end

  // Control and general purpose output registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= RST_CTRL;
      gp_out_q <= '0;
    end else begin
      if (wr_go && wb_adr_i == ADR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
      if (wr_go && wb_adr_i == ADR_GP_OUT && wb_sel_i[0]) begin
        gp_out_q <= wb_dat_i[NUM_OUT-1:0];
      end
    end
  end

  // Sticky events; a set in the same cycle as a clear wins
  // error flag
  assign ev_set[EV_CFG_ERR] = (in_wr && !in_ok) || (out_wr && !out_ok);
  assign ev_set[EV_LAUNCH] = action_d.launch;
  assign ev_set[EV_BREAK] = action_d.brk;
  assign ev_set[EV_CAPTURE] = action_d.capture;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      event_q <= '0;
    end else if (wr_go && wb_adr_i == ADR_EVENT && wb_sel_i[0]) begin
      event_q <= (event_q & ~wb_dat_i[3:0]) | ev_set;
    end else begin
      event_q <= event_q | ev_set;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    unique case (wb_adr_i)
      ADR_CTRL: rd_d = ctrl_q;
      ADR_PIN_STAT: rd_d = {24'h0, act_d, in_pin};
      ADR_EVENT: rd_d = {28'h0, event_q};
      ADR_STATUS: rd_d = {21'h0, out_pin, 8'h0} | 32'(action);
      ADR_GP_OUT: rd_d = {29'h0, gp_out_q};
      ADR_CFG_RB: begin
        for (int i = 0; i < NUM_IN; i++) begin
          rd_d[i*6 +: 6] = in_cfg_q[i];
        end
      end
      ADR_IN_CFG, ADR_OUT_CFG: rd_d = '0;
      default: rd_d = '0;
    endcase
  end

  // Wishbone answer register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (rd_go) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  AST_CAPTURE_LINE1: assert property (@(posedge clk_sys) disable iff (reset)
    in_cfg_q[1].fn != IN_CAPTURE && in_cfg_q[2].fn != IN_CAPTURE && in_cfg_q[3].fn != IN_CAPTURE)
    else $error("capture configured off line 1");
  AST_TRIP_LINE3: assert property (@(posedge clk_sys) disable iff (reset)
    (out_cfg_q[0].fn != OUT_TRIP) && (out_cfg_q[1].fn != OUT_TRIP) &&
    !(out_cfg_q[2].fn == OUT_TRIP && out_cfg_q[2].pol))
    else $error("trip output illegal");
  AST_REJECT_KEEPS: assert property (@(posedge clk_sys) disable iff (reset)
    (in_wr && !in_ok) |=> ({in_cfg_q[0], in_cfg_q[1], in_cfg_q[2], in_cfg_q[3]} ==
      $past({in_cfg_q[0], in_cfg_q[1], in_cfg_q[2], in_cfg_q[3]})) && event_q[EV_CFG_ERR])
    else $error("rejected setup changed config");
  AST_JOG_GATED: assert property (@(posedge clk_sys) disable iff (reset)
    (action.jog_pos || action.jog_neg) |-> $past(ctrl_q[CTRL_JOG_EN]))
    else $error("jog without enable");
  AST_MOVE_PIN: assert property (@(posedge clk_sys) disable iff (reset)
    (out_cfg_q[0].fn == OUT_MOVING && $stable(out_cfg_q[0])) |=>
      out_pin[0] == ($past(out_cfg_q[0].pol) ~^ $past(motion.moving)))
    else $error("moving output wrong level");
  AST_STALL_GATE: assert property (@(posedge clk_sys) disable iff (reset)
    (out_cfg_q[0].fn == OUT_STALL && out_cfg_q[0].pol && !ctrl_q[CTRL_STALL_MODE]) |=> !out_pin[0])
    else $error("stall shown without mode");
  AST_LAUNCH_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    action.launch |=> !action.launch)
    else $error("launch longer than one cycle");
  AST_ACK_ONE: assert property (@(posedge clk_sys) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule

// ---- hw/mio_pkg.sv ----
// Package for the motion I/O function mapper: register map, codes and carriers
package mio_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_IN_CFG = 8'h00;
  localparam logic [7:0] ADR_OUT_CFG = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_PIN_STAT = 8'h0C;
  localparam logic [7:0] ADR_EVENT = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_GP_OUT = 8'h18;
  localparam logic [7:0] ADR_CFG_RB = 8'h1C;
  // Setup command field positions: line [3:0], type [12:8], polarity bit 16
  localparam int LINE_LSB = 0;
  localparam int TYPE_LSB = 8;
  localparam int POL_BIT = 16;
  // Control register bits
  localparam int CTRL_JOG_EN = 0;
  localparam int CTRL_STALL_MODE = 1;
  localparam int CTRL_SMALL_FRAME = 2;
  localparam int CTRL_MASK_LSB = 8;
  // Event register bits
  localparam int EV_CFG_ERR = 0;
  localparam int EV_LAUNCH = 1;
  localparam int EV_BREAK = 2;
  localparam int EV_CAPTURE = 3;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 3;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [4:0] RST_IN_TYPE = 5'h00;
  localparam logic [4:0] RST_OUT_TYPE = 5'h10;
  localparam logic RST_POL = 1'b1;
  // Input function codes
  typedef enum logic [4:0] {
    IN_GP = 5'h00, IN_HOME = 5'h01, IN_LIM_POS = 5'h02, IN_LIM_NEG = 5'h03,
    IN_LAUNCH = 5'h04, IN_SOFT_STOP = 5'h05, IN_PAUSE = 5'h06, IN_JOG_POS = 5'h07,
    IN_JOG_NEG = 5'h08, IN_RESET = 5'h0B, IN_CAPTURE = 5'h0C
  } mio_in_fn_t;
  // Output function codes
  typedef enum logic [4:0] {
    OUT_GP = 5'h10, OUT_MOVING = 5'h11, OUT_ERROR = 5'h12, OUT_STALL = 5'h13,
    OUT_VEL_CHG = 5'h14, OUT_LOCKED = 5'h15, OUT_TO_POS = 5'h17, OUT_HYB_ON = 5'h18,
    OUT_MAKEUP = 5'h19, OUT_TRIP = 5'h1C, OUT_ATTN = 5'h1D
  } mio_out_fn_t;
  // Configuration carried per line
  typedef struct packed {
    logic [4:0] fn;
    logic pol;
  } mio_line_cfg_t;
  // Motion state fed into the mapper
  typedef struct packed {
    logic moving;
    logic error;
    logic stall;
    logic vel_changing;
    logic locked_rotor;
    logic to_position;
    logic hybrid_on;
    logic makeup;
    logic trip;
    logic [7:0] status;
  } mio_motion_t;
  // Actions requested from the motion engine and interpreter
  typedef struct packed {
    logic home;
    logic limit_pos;
    logic limit_neg;
    logic launch;
    logic soft_stop;
    logic pause;
    logic jog_pos;
    logic jog_neg;
    logic brk;
    logic capture;
  } mio_action_t;
endpackage

// ---- verification/mio_far_side.sv ----
// Far-side model: switch contacts into the input pins, loads on the outputs
`timescale 1ns/100ps
module mio_far_side (
  input wire logic clk_sys,
  input wire logic [3:0] sw,
  output logic [3:0] in_pin,
  input wire logic [2:0] out_pin,
  output logic [2:0] load
);
  // Contacts land one clock after the bench moves them, like a real input stage
  always_ff @(posedge clk_sys) begin
    in_pin <= sw;
  end
  // Loads only follow the driven pins
  assign load = out_pin;
endmodule

// ---- verification/mio_mapper_tb.sv ----
// Self-checking bench for the motion I/O function mapper
`timescale 1ns/100ps
module mio_mapper_tb;
  import mio_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, sw = 4'h0, in_pin;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, ctrl = 32'h0;
  logic wb_ack_o, jog_enable_flag, stall_detect_mode;
  logic [2:0] out_pin, gp = 3'h0;
  logic [6:0] lvl;
  mio_motion_t motion = '0;
  mio_action_t action;
  logic [4:0] in_fn [4] = '{default: 5'h00};
  logic [4:0] out_fn [3] = '{default: 5'h10};
  logic in_pol [4] = '{default: 1'b1};
  logic out_pol [3] = '{default: 1'b1};
  logic [4:0] ifn [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0B, 5'h0C};
  logic [4:0] ofn [11] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h17, 5'h18, 5'h19, 5'h1C, 5'h1D};
  // Refused requests, packed as direction, line, type, polarity
  logic [19:0] bad [11] = '{20'h00010, 20'h05010, 20'h020C0, 20'h01091, 20'h010D0, 20'h010C0,
    20'h111C0, 20'h131C1, 20'h14110, 20'h12161, 20'h10101};
  int n_fail = 0, compares = 0;
  logic [23:0] pulses = 24'h0, e_pulses = 24'h0;
  always #2 clk_sys = ~clk_sys;
  // Count one-shot pulses seen on the action outputs: launch, break, capture
  always @(posedge clk_sys) if (!reset) pulses <= pulses + {7'h0, action.capture, 7'h0, action.brk, 7'h0, action.launch};
  assign lvl = {action.home, action.limit_pos, action.limit_neg, action.soft_stop, action.pause,
    action.jog_pos, action.jog_neg};
  mio_mapper i_dut (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .in_pin, .out_pin, .motion, .action, .jog_enable_flag, .stall_detect_mode);
  mio_far_side i_far (.clk_sys, .sw, .in_pin, .out_pin, .load());
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
    // Only the watchdog ends a wait that never sees ack
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic logic in_ok(int ln, logic [4:0] fn);
    return ln >= 1 && ln <= 4 && (fn <= 5'h08 || fn == 5'h0B || (fn == 5'h0C && ln == 1 && !ctrl[2]));
  endfunction
  function automatic logic out_ok(int ln, logic [4:0] fn, logic pol);
    return ln >= 1 && ln <= 3 && fn >= 5'h10 && fn != 5'h16 && fn != 5'h1A && fn != 5'h1B
      && fn < 5'h1E && (fn != 5'h1C || (ln == 3 && !pol));
  endfunction
  function automatic logic [31:0] exp_rb();
    logic [31:0] r = 32'h0;
    for (int i = 0; i < 4; i++) r[i*6 +: 6] = {in_fn[i], in_pol[i]};
    return r;
  endfunction
  // Pin level is the condition, turned round when the line is active low
  function automatic logic [2:0] exp_out();
    logic [2:0] r;
    logic c;
    for (int i = 0; i < 3; i++) begin
      case (out_fn[i])
        5'h10: c = gp[i];
        5'h11: c = motion.moving;
        5'h12: c = motion.error;
        5'h13: c = motion.stall & ctrl[1];
        5'h14: c = motion.vel_changing;
        5'h15: c = motion.locked_rotor;
        5'h17: c = motion.to_position;
        5'h18: c = motion.hybrid_on;
        5'h19: c = motion.makeup;
        5'h1C: c = motion.trip;
        default: c = |(motion.status & ctrl[15:8]);
      endcase
      r[i] = out_pol[i] ? c : !c;
    end
    return r;
  endfunction
  function automatic logic [6:0] exp_lvl();
    logic [6:0] r = 7'h00;
    for (int i = 0; i < 4; i++) begin
      if ((in_pol[i] ? sw[i] : !sw[i]) == 1'b1) begin
        case (in_fn[i])
          5'h01: r[6] = 1'b1;
          5'h02: r[5] = 1'b1;
          5'h03: r[4] = 1'b1;
          5'h05: r[3] = 1'b1;
          5'h06: r[2] = 1'b1;
          5'h07: r[1] = ctrl[0];
          5'h08: r[0] = ctrl[0];
          default: ;
        endcase
      end
    end
    return r;
  endfunction
  // A setup write, then the error flag and the readback; refused writes keep the model as it was
  task automatic cfg(input logic o, input int ln, input logic [4:0] fn, input logic pol);
    logic ok;
    ok = o ? out_ok(ln, fn, pol) : in_ok(ln, fn);
    wb(1'b1, o ? ADR_OUT_CFG : ADR_IN_CFG, {15'h0, pol, 3'h0, fn, 4'h0, 4'(ln)});
    if (ok && o) begin
      out_fn[ln-1] = fn;
      out_pol[ln-1] = pol;
    end
    if (ok && !o) begin
      in_fn[ln-1] = fn;
      in_pol[ln-1] = pol;
    end
    wb(1'b0, ADR_EVENT, 32'h0);
    chk("cfg_error", 32'(!ok), 32'(rd[EV_CFG_ERR]));
    wb(1'b1, ADR_EVENT, 32'h1);
    wb(1'b0, ADR_CFG_RB, 32'h0);
    chk("cfg_readback", exp_rb(), rd);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hEB553918));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    wb(1'b0, ADR_CFG_RB, 32'h0);
    chk("rb_reset", exp_rb(), rd);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("out_reset", 32'(exp_out()), 32'(out_pin));
    $display("test reset done");
    // Every input function, both polarities at random, jog enable off then on
    for (int j = 0; j < 2; j++) begin
      ctrl = 32'(j);
      wb(1'b1, ADR_CTRL, ctrl);
      for (int k = 0; k < 11; k++) begin
        int ln;
        logic p;
        ln = ifn[k] == 5'h0C ? 1 : $urandom_range(1, 4);
        p = 1'($urandom_range(0, 1));
        sw[ln-1] <= !p;
        repeat (4) @(posedge clk_sys);
        cfg(1'b0, ln, ifn[k], p);
        wb(1'b1, ADR_EVENT, 32'hF);
        sw[ln-1] <= p;
        repeat (4) @(posedge clk_sys);
        chk("action_levels", 32'(exp_lvl()), 32'(lvl));
        wb(1'b0, ADR_EVENT, 32'h0);
        chk("events", {28'h0, ifn[k] == 5'h0C, ifn[k] == 5'h0B, ifn[k] == 5'h04, 1'b0}, rd);
        e_pulses = e_pulses + {7'h0, ifn[k] == 5'h0C, 7'h0, ifn[k] == 5'h0B, 7'h0, ifn[k] == 5'h04};
        chk("pulses", 32'(e_pulses), 32'(pulses));
        wb(1'b0, ADR_PIN_STAT, 32'h0);
        chk("pin_raw", 32'(sw), 32'(rd[3:0]));
        if (ifn[k] == 5'h00) chk("pin_active", 32'h1, 32'(rd[3+ln]));
        sw[ln-1] <= !p;
        repeat (4) @(posedge clk_sys);
        chk("action_idle", 32'(exp_lvl()), 32'(lvl));
        cfg(1'b0, ln, 5'h00, 1'b1);
      end
    end
    $display("test inputs done");
    // Refused combinations, capture forbidden on the small frame
    ctrl = 32'h4;
    wb(1'b1, ADR_CTRL, ctrl);
    for (int k = 0; k < 11; k++) cfg(bad[k][16], int'(bad[k][15:12]), bad[k][8:4], bad[k][0]);
    chk("out_kept", 32'(exp_out()), 32'(out_pin));
    $display("test refusals done");
    // Random output functions against random motion state
    for (int k = 0; k < 60; k++) begin
      int ln;
      logic [4:0] f;
      logic p;
      f = ofn[$urandom_range(0, 10)];
      ln = f == 5'h1C ? 3 : $urandom_range(1, 3);
      p = f == 5'h1C ? 1'b0 : 1'($urandom_range(0, 1));
      cfg(1'b1, ln, f, p);
      ctrl = {16'h0, 8'($urandom), 5'h0, 3'($urandom_range(0, 3))};
      wb(1'b1, ADR_CTRL, ctrl);
      gp = 3'($urandom);
      wb(1'b1, ADR_GP_OUT, {29'h0, gp});
      motion <= 17'($urandom);
      repeat (4) @(posedge clk_sys);
      chk("out_pin", 32'(exp_out()), 32'(out_pin));
      chk("ctrl_flags", 32'(ctrl[1:0]), 32'({stall_detect_mode, jog_enable_flag}));
    end
    $display("test outputs done");
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule
